// ---- gcar_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
// Contract
// - bus-idle shutdown bit set: both serial lines low past timeout enters shutdown
// - bus-idle bit set: rising edge of either line wakes; bit resets to 1
// - both shutdown bits clear: any edge on data, clock or interrupt pin wakes
// - bit 5 lets bus charge-fail drive interrupt pin; firmware cannot change it
// - auto thermistor bit: bias and measure sense pin every 1.4 s; resets 1
// - forced-bias bit 3 keeps bias switch on; resets to 0
// - insertion-alert bit 1: detected battery insertion raises alert; resets 0
// - removal-alert bit 0: detected battery removal raises alert; resets 0
// - restore loads termination current from one-time memory or capacity / 10
// - nominal temperature is signed 10 bits in 15:6, sign in bit 15
// - hot coefficient above nominal temperature, cold coefficient below it
// - temperature window: upper 15:8, lower 7:0; learning only strictly inside
module gcar_regs #(
	parameter int unsigned THERM_PERIOD_CYC = gcar_pkg::THERM_CYC
) (
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_srst,
	// register port behind the serial bus
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic        i_reg_fw,
	input  wire logic [15:0] i_reg_wdata,
	output logic      [15:0] o_reg_rdata,
	// serial line levels and shutdown timeout
	input  wire logic        i_sda,
	input  wire logic        i_scl,
	input  wire logic [15:0] i_shdn_timeout_cyc,
	// gauge events
	input  wire logic        i_alert_shutdown_en,
	input  wire logic [5:0]  i_thr_viol,
	input  wire logic        i_batt_insert,
	input  wire logic        i_batt_remove,
	input  wire logic        i_bus_charge_fail_event,
	input  wire logic        i_gauge_charge_fail_event,
	input  wire logic        i_alert_clear,
	// restore sources
	input  wire logic        i_restore,
	input  wire logic        i_otp_term_en,
	input  wire logic [15:0] i_otp_term,
	input  wire logic [15:0] i_stored_design_capacity,
	// learned capacity and temperatures
	input  wire logic        i_fcn_learn_vld,
	input  wire logic [15:0] i_fcn_learn,
	input  wire logic [15:0] i_temperature,
	input  wire logic [15:0] i_avg_temperature,
	// pins and status
	output logic             o_interrupt_output_pin,
	output logic             o_shutdown,
	output logic             o_thermistor_bias_output,
	output logic             o_sense_measure,
	output logic      [5:0]  o_minmax_flags,
	output logic             o_use_hot_coeff,
	output logic             o_use_cold_coeff,
	output logic             o_rcomp_learn_ok
);
	import gcar_pkg::*;

	localparam logic [THERM_CNT_W-1:0] TC_LAST = THERM_CNT_W'(THERM_PERIOD_CYC - 1);
	localparam logic [THERM_CNT_W-1:0] TC_BIAS = THERM_CNT_W'(THERM_PERIOD_CYC - THERM_BIAS_CYC);

	typedef struct packed {
		gcar_pwr_t              pwr;
		logic [15:0]            cfg;
		logic [15:0]            term;
		logic [15:0]            qrt;
		logic [15:0]            fcn;
		logic [15:0]            tnom;
		logic [15:0]            tlim;
		logic [15:0]            rdata;
		logic                   ins_alert;
		logic                   rem_alert;
		logic                   irq;
		logic [5:0]             minmax;
		logic [THERM_CNT_W-1:0] tcnt;
		logic                   bias;
		logic                   meas;
		logic                   hot;
		logic                   cold;
		logic                   learn_ok;
	} gcar_regs_st_t;

	gcar_regs_st_t st;
	gcar_regs_st_t next_st;

	logic [2:0] pin_rise;
	logic [2:0] pin_any;
	logic       idle_run;
	logic       idle_expired;
	logic       alert_now;
	logic       wake;
	logic       enter_shdn;
	logic [15:0] term_from_cap;
	logic [15:0] cfg_wr;

	// edges on sda, scl and our own interrupt pin
	gcar_pin_edges u_edges (
		.i_sys_clk (i_sys_clk),
		.i_srst    (i_srst),
		.i_pins    ({st.irq, i_scl, i_sda}),
		.o_rise    (pin_rise),
		.o_any     (pin_any)
	);

	// bus held low while awake
	assign idle_run = st.cfg[CFG_BUS_IDLE_SHDN] && !i_sda && !i_scl
		&& (st.pwr == PWR_ACTIVE);

	gcar_idle_timer u_idle (
		.i_sys_clk (i_sys_clk),
		.i_srst    (i_srst),
		.i_run     (idle_run),
		.i_limit   (i_shdn_timeout_cyc),
		.o_expired (idle_expired)
	);

	// alert sources that reach the interrupt pin
	assign alert_now = (st.cfg[CFG_ALERT_EN] && (|i_thr_viol))
		|| st.ins_alert || st.rem_alert;

	// shutdown entry; alert path is why software must clear alert shutdown
	assign enter_shdn = idle_expired
		|| (i_alert_shutdown_en && alert_now);

	// wake sources depend on which shutdown bits are set
	assign wake = (st.cfg[CFG_BUS_IDLE_SHDN] && (|pin_rise[1:0]))
		|| (!st.cfg[CFG_BUS_IDLE_SHDN] && !st.cfg[CFG_BATT_PIN_SHDN]
		&& (|pin_any))
		|| (st.cfg[CFG_BATT_PIN_SHDN] && i_batt_insert);

	// constant divide; small enough to settle within one cycle
	assign term_from_cap = i_stored_design_capacity / TERM_DIV;

	// firmware writes keep the protected enable bits
	assign cfg_wr = i_reg_fw
		? ((i_reg_wdata & ~CFG_FW_PROT) | (st.cfg & CFG_FW_PROT))
		: i_reg_wdata;

	// next-state of the whole bank
	always_comb begin
		next_st = st;

		// power state
		unique case (st.pwr)
			PWR_ACTIVE: begin
				if (enter_shdn) begin
					next_st.pwr = PWR_SHDN;
				end
			end
			PWR_SHDN: begin
				if (wake) begin
					next_st.pwr = PWR_ACTIVE;
				end
			end
			default: begin
				next_st.pwr = PWR_ACTIVE;
			end
		endcase

		// host and firmware writes
		if (i_reg_wr) begin
			unique case (i_reg_addr)
				OFS_CFG:  next_st.cfg  = cfg_wr;
				OFS_TERM: next_st.term = i_reg_wdata;
				OFS_QRT:  next_st.qrt  = i_reg_wdata;
				OFS_FCN:  next_st.fcn  = i_reg_wdata;
				OFS_TNOM: next_st.tnom = i_reg_wdata & TNOM_MASK;
				OFS_TLIM: next_st.tlim = i_reg_wdata;
				default:  next_st.cfg  = st.cfg;
			endcase
		end

		// restore beats a same-cycle host write
		if (i_restore) begin
			next_st.term = i_otp_term_en ? i_otp_term : term_from_cap;
		end

		// learned value beats a same-cycle host write
		if (i_fcn_learn_vld) begin
			next_st.fcn = i_fcn_learn;
		end

		// sticky battery alerts; a new event wins over clear
		next_st.ins_alert = (st.cfg[CFG_INSERT_ALERT] && i_batt_insert)
			|| (st.ins_alert && !i_alert_clear);
		next_st.rem_alert = (st.cfg[CFG_REMOVAL_ALERT] && i_batt_remove)
			|| (st.rem_alert && !i_alert_clear);

		// min/max flags follow violations whatever the alert enable
		next_st.minmax = i_thr_viol;

		// interrupt pin
		next_st.irq = alert_now
			|| (st.cfg[CFG_BUS_CF_IRQ] && i_bus_charge_fail_event)
			|| (st.cfg[CFG_GAUGE_CF_IRQ] && i_gauge_charge_fail_event);

		// thermistor period counter; cleared while shut down or with auto off
		next_st.meas = 1'b0;
		if (st.cfg[CFG_AUTO_THERM] && (st.pwr == PWR_ACTIVE)) begin
			if (st.tcnt >= TC_LAST) begin
				next_st.tcnt = '0;
				next_st.meas = 1'b1;
			end else begin
				next_st.tcnt = st.tcnt + THERM_CNT_W'(1);
			end
		end else begin
			next_st.tcnt = '0;
		end

		// bias settles before the measurement, or is held by force
		next_st.bias = st.cfg[CFG_FORCED_BIAS]
			|| (st.cfg[CFG_AUTO_THERM] && (st.pwr == PWR_ACTIVE)
			&& ((next_st.tcnt >= TC_BIAS) || next_st.meas));

		// compensation choice against nominal temperature
		next_st.hot  = $signed(i_temperature) > $signed(st.tnom);
		next_st.cold = $signed(i_temperature) < $signed(st.tnom);

		// learning window, whole degrees in the upper byte
		next_st.learn_ok = ($signed(i_avg_temperature[15:8]) > $signed(st.tlim[7:0]))
			&& ($signed(i_avg_temperature[15:8]) < $signed(st.tlim[15:8]));

		// read data, registered; unmapped reads zero
		if (i_reg_rd) begin
			unique case (i_reg_addr)
				OFS_CFG:  next_st.rdata = st.cfg;
				OFS_TERM: next_st.rdata = st.term;
				OFS_FWV:  next_st.rdata = FW_VERSION;
				OFS_QRT:  next_st.rdata = st.qrt;
				OFS_FCN:  next_st.rdata = st.fcn;
				OFS_TNOM: next_st.rdata = st.tnom & TNOM_MASK;
				OFS_TLIM: next_st.rdata = st.tlim;
				default:  next_st.rdata = 16'h0000;
			endcase
		end
	end

	// state register with synchronous reset
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			st.pwr       <= PWR_ACTIVE;
			st.cfg       <= CFG_RST;
			st.term      <= TERM_RST;
			st.qrt       <= QRT_RST;
			st.fcn       <= FCN_RST;
			st.tnom      <= TNOM_RST;
			st.tlim      <= TLIM_RST;
			st.rdata     <= 16'h0000;
			st.ins_alert <= 1'b0;
			st.rem_alert <= 1'b0;
			st.irq       <= 1'b0;
			st.minmax    <= 6'h00;
			st.tcnt      <= '0;
			st.bias      <= 1'b0;
			st.meas      <= 1'b0;
			st.hot       <= 1'b0;
			st.cold      <= 1'b0;
			st.learn_ok  <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from flops
	assign o_reg_rdata              = st.rdata;
	assign o_interrupt_output_pin   = st.irq;
	assign o_shutdown               = (st.pwr == PWR_SHDN);
	assign o_thermistor_bias_output = st.bias;
	assign o_sense_measure          = st.meas;
	assign o_minmax_flags           = st.minmax;
	assign o_use_hot_coeff          = st.hot;
	assign o_use_cold_coeff         = st.cold;
	assign o_rcomp_learn_ok         = st.learn_ok;
endmodule
`default_nettype wire

// ---- gcar_pkg.sv ----
package gcar_pkg;
	// register offsets on the serial register port
	localparam logic [7:0] OFS_CFG  = 8'h1D;
	localparam logic [7:0] OFS_TERM = 8'h1E;
	localparam logic [7:0] OFS_FWV  = 8'h21;
	localparam logic [7:0] OFS_QRT  = 8'h22;
	localparam logic [7:0] OFS_FCN  = 8'h23;
	localparam logic [7:0] OFS_TNOM = 8'h24;
	localparam logic [7:0] OFS_TLIM = 8'h25;

	// configuration field positions
	localparam int CFG_REMOVAL_ALERT = 0;
	localparam int CFG_INSERT_ALERT  = 1;
	localparam int CFG_ALERT_EN      = 2;
	localparam int CFG_FORCED_BIAS   = 3;
	localparam int CFG_AUTO_THERM    = 4;
	localparam int CFG_BUS_CF_IRQ    = 5;
	localparam int CFG_BUS_IDLE_SHDN = 6;
	localparam int CFG_BATT_PIN_SHDN = 10;
	localparam int CFG_GAUGE_CF_IRQ  = 15;

	// values after reset
	localparam logic [15:0] CFG_RST     = 16'h2350;
	localparam logic [15:0] TERM_RST    = 16'h0000;
	localparam logic [15:0] QRT_RST     = 16'h0000;
	localparam logic [15:0] FCN_RST     = 16'h0000;
	localparam logic [15:0] TNOM_RST    = 16'h0000;
	localparam logic [15:0] TLIM_RST    = 16'h0000;
	// arbitrary neutral firmware version word
	localparam logic [15:0] FW_VERSION  = 16'h0100;

	// bits firmware may not touch, and stored bits of the nominal temperature
	localparam logic [15:0] CFG_FW_PROT = 16'h8020;
	localparam logic [15:0] TNOM_MASK   = 16'hFFC0;
	localparam logic [15:0] TERM_DIV    = 16'h000A;

	// thermistor measurement timing
	localparam int CLK_MHZ          = 200;
	localparam int THERM_PERIOD_MS  = 1400;
	localparam int THERM_CYC        = THERM_PERIOD_MS * 1000 * CLK_MHZ;
	localparam int THERM_CNT_W      = 29;
	localparam int THERM_BIAS_CYC   = 16;

	// power state, one-hot
	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'b01,
		PWR_SHDN   = 2'b10
	} gcar_pwr_t;
endpackage

// ---- gcar_pin_edges.sv ----
`timescale 1ns/100ps
`default_nettype none
module gcar_pin_edges (
	// clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_srst,
	// pins: sda, scl, interrupt
	input  wire logic [2:0] i_pins,
	// edges seen this cycle
	output logic      [2:0] o_rise,
	output logic      [2:0] o_any
);
	import gcar_pkg::*;

	typedef struct packed {
		logic [2:0] prev;
	} gcar_edge_st_t;

	gcar_edge_st_t st;
	gcar_edge_st_t next_st;

	// previous level only; pins are already synchronous
	always_comb begin
		next_st.prev = i_pins;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			st.prev <= 3'h3;
		end else begin
			st <= next_st;
		end
	end

	// prev resets to the idle levels (lines high, interrupt low): no false edge after reset
	assign o_rise = i_pins & ~st.prev;
	assign o_any  = (i_pins ^ st.prev) & {3{~i_srst}};
endmodule
`default_nettype wire

// ---- gcar_idle_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
module gcar_idle_timer (
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_srst,
	// condition and limit in cycles
	input  wire logic        i_run,
	input  wire logic [15:0] i_limit,
	// level once the condition outlasted the limit
	output logic             o_expired
);
	import gcar_pkg::*;

	typedef struct packed {
		logic [16:0] cnt;
	} gcar_tmr_st_t;

	gcar_tmr_st_t st;
	gcar_tmr_st_t next_st;

	// count while held, restart when released; saturate past the limit
	always_comb begin
		next_st = st;
		if (!i_run) begin
			next_st.cnt = 17'h00000;
		end else if (st.cnt <= {1'b0, i_limit}) begin
			next_st.cnt = st.cnt + 17'h00001;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			st.cnt <= 17'h00000;
		end else begin
			st <= next_st;
		end
	end

	// strictly longer than the limit
	assign o_expired = i_run && (st.cnt > {1'b0, i_limit});
endmodule
`default_nettype wire

// ---- gcar_host_lines.sv ----
`timescale 1ns/100ps
`default_nettype none
module gcar_host_lines (
	// clock and commands from the bench
	input  wire logic i_sys_clk,
	input  wire logic i_hold_low,
	input  wire logic i_alerts_on,
	// serial lines, pulled up when released, and the alert shutdown enable
	output logic      o_sda = 1'b1,
	output logic      o_scl = 1'b1,
	output logic      o_alert_shutdown_en = 1'b1
);
	// host moves just after the edge; a released line goes to the pull-up
	always @(posedge i_sys_clk) begin
		o_sda <= ~i_hold_low;
		o_scl <= ~i_hold_low;
		o_alert_shutdown_en <= ~i_alerts_on;
	end
endmodule
`default_nettype wire

// ---- gcar_regs_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module gcar_regs_chk
	import gcar_pkg::*;
#(
	parameter int unsigned THERM_PERIOD_CYC = 64
) (
	// clock, reset and register port
	input  wire logic        i_sys_clk,
	input  wire logic        i_srst,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [15:0] o_reg_rdata,
	// lines and events
	input  wire logic        i_sda,
	input  wire logic        i_scl,
	input  wire logic        i_alert_shutdown_en,
	input  wire logic [5:0]  i_thr_viol,
	input  wire logic        i_batt_insert,
	input  wire logic        i_restore,
	input  wire logic        i_otp_term_en,
	input  wire logic [15:0] i_otp_term,
	input  wire logic [15:0] i_stored_design_capacity,
	// outputs watched
	input  wire logic        o_interrupt_output_pin,
	input  wire logic        o_shutdown,
	input  wire logic        o_thermistor_bias_output,
	input  wire logic        o_sense_measure,
	input  wire logic [5:0]  o_minmax_flags,
	input  wire logic        o_use_hot_coeff,
	input  wire logic        o_use_cold_coeff
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	// plain read; a write in the same cycle would blur the expectation
	sequence s_rd(logic [7:0] a);
		i_reg_rd && !i_reg_wr && i_reg_addr == a;
	endsequence
	sequence s_restore_rd;
		i_restore ##1 s_rd(OFS_TERM);
	endsequence
	a_tnom_low_zero: assert property (s_rd(OFS_TNOM) |=> o_reg_rdata[5:0] == 6'h00)
		else $error("nominal temperature low bits not zero");
	a_restore_term: assert property (s_restore_rd |=> o_reg_rdata == ($past(i_otp_term_en, 2) ?
		$past(i_otp_term, 2) : $past(i_stored_design_capacity, 2) / 16'h000A))
		else $error("termination current not restored");
	a_flags_follow: assert property (!$past(i_srst) |-> o_minmax_flags == $past(i_thr_viol))
		else $error("min max flags do not follow violations");
	a_coeff_excl: assert property (!(o_use_hot_coeff && o_use_cold_coeff))
		else $error("hot and cold coefficients together");
	a_shdn_cause: assert property ($rose(o_shutdown) |-> $past(!i_sda && !i_scl) || $past(i_alert_shutdown_en))
		else $error("shutdown without idle lines or alert");
	a_wake_edge: assert property ($fell(o_shutdown) |-> $past(i_sda) != $past(i_sda, 2)
		|| $past(i_scl) != $past(i_scl, 2) || $past(i_batt_insert)
		|| $past(o_interrupt_output_pin) != $past(o_interrupt_output_pin, 2))
		else $error("wake without an edge");
	a_measure_pulse: assert property (o_sense_measure |=> !o_sense_measure)
		else $error("measure pulse longer than one cycle");
	a_bias_measure: assert property (o_sense_measure |-> o_thermistor_bias_output)
		else $error("measurement without bias");
endmodule

bind gcar_regs gcar_regs_chk #(.THERM_PERIOD_CYC(THERM_PERIOD_CYC)) i_gcar_regs_chk (.i_sys_clk(i_sys_clk),
	.i_srst(i_srst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
	.i_sda(i_sda), .i_scl(i_scl), .i_alert_shutdown_en(i_alert_shutdown_en), .i_thr_viol(i_thr_viol),
	.i_batt_insert(i_batt_insert), .i_restore(i_restore), .i_otp_term_en(i_otp_term_en), .i_otp_term(i_otp_term),
	.i_stored_design_capacity(i_stored_design_capacity), .o_interrupt_output_pin(o_interrupt_output_pin),
	.o_shutdown(o_shutdown), .o_thermistor_bias_output(o_thermistor_bias_output), .o_sense_measure(o_sense_measure),
	.o_minmax_flags(o_minmax_flags), .o_use_hot_coeff(o_use_hot_coeff), .o_use_cold_coeff(o_use_cold_coeff));
`default_nettype wire

// ---- gcar_regs_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module gcar_regs_bench;
	import gcar_pkg::*;
	logic        clk, srst, rd, wr, fw, hold, alon, sda, scl, alert_shutdown_en, ins, rem, bcf, aclr, rsto, otp_en, fvld;
	logic        shdn, intp, bias, meas, hot, cold, lok;
	logic [7:0]  addr;
	logic [5:0]  viol, flags;
	logic [15:0] wdata, rdata, otp, cap, temp, avg, flrn;
	int          miscompares, tests_run, n;

	gcar_host_lines i_gcar_host_lines (.i_sys_clk(clk), .i_hold_low(hold), .i_alerts_on(alon), .o_sda(sda),
		.o_scl(scl), .o_alert_shutdown_en(alert_shutdown_en));
	// short thermistor period keeps the run brief
	gcar_regs #(.THERM_PERIOD_CYC(64)) i_gcar_regs (.i_sys_clk(clk), .i_srst(srst), .i_reg_addr(addr),
		.i_reg_wr(wr), .i_reg_rd(rd), .i_reg_fw(fw), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_sda(sda),
		.i_scl(scl), .i_shdn_timeout_cyc(16'h000A), .i_alert_shutdown_en(alert_shutdown_en), .i_thr_viol(viol),
		.i_batt_insert(ins), .i_batt_remove(rem), .i_bus_charge_fail_event(bcf),
		.i_gauge_charge_fail_event(1'b0), .i_alert_clear(aclr), .i_restore(rsto), .i_otp_term_en(otp_en),
		.i_otp_term(otp), .i_stored_design_capacity(cap), .i_fcn_learn_vld(fvld), .i_fcn_learn(flrn),
		.i_temperature(temp), .i_avg_temperature(avg), .o_interrupt_output_pin(intp), .o_shutdown(shdn),
		.o_thermistor_bias_output(bias), .o_sense_measure(meas), .o_minmax_flags(flags),
		.o_use_hot_coeff(hot), .o_use_cold_coeff(cold), .o_rcomp_learn_ok(lok));

	// compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	// one-cycle strobes, inputs moved on the falling edge
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		chk(rdata, exp);
	endtask
	// a whole number of periods gives a count that does not depend on phase
	task automatic meas_cnt(output int c);
		c = 0;
		repeat (128) begin
			@(negedge clk);
			if (meas === 1'b1) c++;
		end
	endtask
	task automatic close_out();
		$display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
		if (miscompares == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		srst = 1'b1;
		{rd, wr, fw, hold, alon, ins, rem, bcf, aclr, rsto, otp_en, fvld} = '0;
		{addr, viol, wdata, temp, avg, flrn} = '0;
		otp = 16'h0ABC;
		cap = 16'h04D2;
		miscompares = 0;
		tests_run = 0;
		cyc(6);
		srst = 1'b0;
		// reset values, read-only and unmapped places
		rd_chk(OFS_CFG, CFG_RST);
		wr_reg(OFS_FWV, 16'h1234);
		rd_chk(OFS_FWV, FW_VERSION);
		rd_chk(8'h30, 16'h0000);
		wr_reg(OFS_FCN, 16'hA5A5);
		rd_chk(OFS_FCN, 16'hA5A5);
		// learned capacity replaces the stored word
		flrn = 16'h5A5A;
		fvld = 1'b1;
		cyc(1);
		fvld = 1'b0;
		rd_chk(OFS_FCN, 16'h5A5A);
		meas_cnt(n);
		chk(16'(n), 16'h0002);
		// firmware cannot move bits 15 and 5; forced bias with auto off
		wr_reg(OFS_CFG, 16'h0028);
		fw = 1'b1;
		wr_reg(OFS_CFG, 16'h8008);
		fw = 1'b0;
		rd_chk(OFS_CFG, 16'h0028);
		cyc(2);
		chk(bias, 1'b1);
		meas_cnt(n);
		chk(16'(n), 16'h0000);
		// idle bus shutdown and wake on rising lines
		wr_reg(OFS_CFG, CFG_RST);
		hold = 1'b1;
		cyc(20);
		chk(shdn, 1'b1);
		hold = 1'b0;
		cyc(3);
		chk(shdn, 1'b0);
		// interrupt sources
		alon = 1'b1;
		wr_reg(OFS_CFG, 16'h0067);
		bcf = 1'b1;
		cyc(3);
		chk(intp, 1'b1);
		bcf = 1'b0;
		viol = 6'h04;
		cyc(3);
		chk(intp, 1'b1);
		viol = 6'h00;
		cyc(3);
		chk(intp, 1'b0);
		ins = 1'b1;
		cyc(1);
		ins = 1'b0;
		cyc(3);
		chk(intp, 1'b1);
		aclr = 1'b1;
		cyc(1);
		aclr = 1'b0;
		rem = 1'b1;
		cyc(1);
		rem = 1'b0;
		cyc(3);
		chk(intp, 1'b1);
		wr_reg(OFS_CFG, 16'h0060);
		aclr = 1'b1;
		cyc(1);
		aclr = 1'b0;
		rem = 1'b1;
		viol = 6'h3F;
		cyc(1);
		rem = 1'b0;
		cyc(3);
		chk(intp, 1'b0);
		chk(flags, 6'h3F);
		viol = 6'h00;
		// restore from capacity, then from one-time memory
		// restore stays up into the read, so the read follows it directly
		rsto = 1'b1;
		rd_chk(OFS_TERM, 16'h007B);
		rsto = 1'b0;
		otp_en = 1'b1;
		rsto = 1'b1;
		rd_chk(OFS_TERM, 16'h0ABC);
		rsto = 1'b0;
		// nominal temperature and the learning window
		wr_reg(OFS_TNOM, 16'hFFFF);
		rd_chk(OFS_TNOM, 16'hFFC0);
		wr_reg(OFS_TNOM, 16'h1900);
		temp = 16'h2000;
		cyc(3);
		chk({hot, cold}, 2'b10);
		temp = 16'hF000;
		cyc(3);
		chk({hot, cold}, 2'b01);
		temp = 16'h1900;
		cyc(3);
		chk({hot, cold}, 2'b00);
		wr_reg(OFS_TLIM, 16'h2810);
		avg = 16'h1E00;
		cyc(3);
		chk(lok, 1'b1);
		avg = 16'h2800;
		cyc(3);
		chk(lok, 1'b0);
		// alert with alert shutdown turned back on shuts down; the interrupt pin edge wakes
		wr_reg(OFS_CFG, 16'h0004);
		alon = 1'b0;
		viol = 6'h01;
		cyc(3);
		chk(shdn, 1'b1);
		viol = 6'h00;
		cyc(4);
		chk(shdn, 1'b0);
		close_out();
	end
endmodule
`default_nettype wire
